/* File: swmh_regbank.sv */
// host-visible register bank of the single-wire bus master
`timescale 1ns/10ps
`default_nettype none
`include "swmh_params.svh"
module swmh_regbank
   import swmh_pkg::*;
(
   // clock and reset
   input  wire logic       clk_sys,
   input  wire logic       reset,
   input  wire logic       sleep_pin_n,
   // byte access from the serial host front end
   input  wire logic       addr_wr,
   input  wire logic [7:0] addr_in,
   input  wire logic       data_wr,
   input  wire logic [7:0] data_in,
   input  wire logic       read_ack,
   input  wire logic       read_take,
   output var  logic [7:0] read_data,
   // command hand-off to the line engine
   output var  logic       cmd_valid,
   output var  logic [7:0] cmd_code,
   output var  logic [7:0] cmd_param,
   // results from the line engine
   input  wire logic       line_level,
   input  wire logic       line_active,
   input  wire logic       op_done,
   input  wire swmh_op_t   op_kind,
   input  wire logic       res_first,
   input  wire logic       res_second,
   input  wire logic       res_dir,
   input  wire logic       res_short,
   input  wire logic       res_presence,
   input  wire logic [7:0] res_byte,
   // configuration outputs
   output var  logic [3:0] setup_bits,
   output var  logic [7:0] reset_low_time,
   output var  logic [7:0] presence_sample_time,
   output var  logic [7:0] write_zero_low_time,
   output var  logic [7:0] recovery_time,
   output var  logic [7:0] weak_pullup_resistance,
   output var  logic [7:0] write_one_low_time
);
   // ==================================================
   // helpers

   // region decode, shared by read and write paths
   function automatic swmh_region_t region_of(input logic [7:0] a);
      if (a <= `SWMH_SCRATCH_LAST)
         region_of = SWMH_RG_SCRATCH;
      else if (a >= `SWMH_REG_BASE && a < `SWMH_NV_BASE)
         region_of = SWMH_RG_REG;
      else if (a >= `SWMH_PAGE0_FIRST && a <= `SWMH_PAGE1_LAST)
         region_of = SWMH_RG_PAGE;
      else
         region_of = SWMH_RG_NONE;
   endfunction

   // ==================================================
   // state
   logic [7:0] ptr_reg;          // shared address and read pointer
   logic [7:0] state_reg;        // master state byte, busy bit separate
   logic [7:0] rxbyte_reg;       // last byte read from the line
   logic [3:0] setup_reg;        // master setup, lower nibble only
   logic [7:0] rstl_reg;         // reset low time
   logic [7:0] msp_reg;          // presence sample time
   logic [7:0] wol_reg;          // write zero low time
   logic [7:0] rec_reg;          // recovery time
   logic [7:0] wpu_reg;          // weak pullup select
   logic [7:0] w1l_reg;          // fast write one low time
   logic       cmd_have_reg;     // command code seen, waiting parameter
   logic [7:0] cmd_code_reg;     // held command code
   logic [7:0] scr_rd;           // scratchpad read data
   logic [7:0] pg_rd;            // page read data
   logic [7:0] mux_next;         // byte that the pointer selects
   logic       wr_cmd;           // write landing on the command entry
   logic       int_reset;        // any internal reset source
   logic       mreset_cmd;       // master reset command accepted
   logic       is_line_cmd;      // parameter byte pending or master reset; pointer returns to status

   // command codes are not part of this bank; the code f0h is master reset
   localparam logic [7:0] CMD_MRESET = 8'hf0;

   assign wr_cmd      = data_wr && ptr_reg == `SWMH_ADDR_CMD;
   assign mreset_cmd  = wr_cmd && !cmd_have_reg && data_in == CMD_MRESET;
   assign int_reset   = reset || !sleep_pin_n || mreset_cmd;
   assign is_line_cmd = cmd_have_reg || mreset_cmd;

   // ==================================================
   // storage blocks
   swmh_scratch u_scratch
   (
      .clk_sys (clk_sys),
      .wr_en   (data_wr && region_of(ptr_reg) == SWMH_RG_SCRATCH),
      .wr_idx  (ptr_reg[6:0]),
      .wr_data (data_in),
      .rd_idx  (ptr_reg[6:0]),
      .rd_data (scr_rd)
   );

   swmh_pages u_pages
   (
      .clk_sys (clk_sys),
      .wr_en   (data_wr && region_of(ptr_reg) == SWMH_RG_PAGE),
      .wr_idx  (ptr_reg[5:0]),
      .wr_data (data_in),
      .rd_idx  (ptr_reg[5:0]),
      .rd_data (pg_rd)
   );

   // ==================================================
   // pointer: set by address phase, by commands, advanced by reads
   always_ff @(posedge clk_sys)
   begin
      if (reset)
         ptr_reg <= `SWMH_ADDR_STATE;
      else if (addr_wr)
         ptr_reg <= addr_in;
      else if (is_line_cmd && wr_cmd)
         ptr_reg <= `SWMH_ADDR_STATE;
      else if (data_wr && !wr_cmd)
         ptr_reg <= ptr_reg + 8'h01;
      else if (read_take)
         ptr_reg <= ptr_reg + 8'h01;
   end

   // ==================================================
   // command entry: code then parameter, one command at a time
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         cmd_have_reg <= 1'b0;
         cmd_code_reg <= 8'h00;
         cmd_valid    <= 1'b0;
         cmd_code     <= 8'h00;
         cmd_param    <= 8'h00;
      end
      else
      begin
         cmd_valid <= 1'b0;
         if (wr_cmd && !mreset_cmd)
         begin
            // host keeps to one command at a time
            if (!cmd_have_reg)
            begin
               cmd_have_reg <= 1'b1;
               cmd_code_reg <= data_in;
            end
            else
            begin
               cmd_have_reg <= 1'b0;
               cmd_valid    <= 1'b1;
               cmd_code     <= cmd_code_reg;
               cmd_param    <= data_in;
            end
         end
         else if (addr_wr)
            cmd_have_reg <= 1'b0;      // abandoned half command
      end
   end

   // ==================================================
   // master setup with nibble-complement check
   always_ff @(posedge clk_sys)
   begin
      if (int_reset)
         setup_reg <= 4'(`SWMH_SETUP_RESET);
      else if (data_wr && ptr_reg == `SWMH_ADDR_SETUP && data_in[7:4] == ~data_in[3:0])
         setup_reg <= data_in[3:0];
   end

   // ==================================================
   // port timing registers, defaults after reset
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         rstl_reg <= `SWMH_RSTL_RESET;
         msp_reg  <= `SWMH_MSP_RESET;
         wol_reg  <= `SWMH_WOL_RESET;
         rec_reg  <= `SWMH_REC_RESET;
         wpu_reg  <= `SWMH_WPU_RESET;
         w1l_reg  <= `SWMH_W1L_RESET;
      end
      else if (data_wr)
      begin
         unique case (ptr_reg)
            `SWMH_ADDR_RSTL: rstl_reg <= data_in;
            `SWMH_ADDR_MSP:  msp_reg  <= data_in;
            `SWMH_ADDR_WOL:  wol_reg  <= data_in;
            `SWMH_ADDR_REC:  rec_reg  <= data_in;
            `SWMH_ADDR_WPU:  wpu_reg  <= data_in;
            `SWMH_ADDR_W1L:  w1l_reg  <= data_in;
            default:         ;          // others handled elsewhere
         endcase
      end
   end

   // ==================================================
   // status byte; each bit only moves with its own event
   always_ff @(posedge clk_sys)
   begin
      if (int_reset)
      begin
         state_reg <= 8'h00;
         state_reg[`SWMH_ST_RST] <= 1'b1;
      end
      else
      begin
         // set of the reset flag is above; setup write clears it
         if (data_wr && ptr_reg == `SWMH_ADDR_SETUP && data_in[7:4] == ~data_in[3:0])
            state_reg[`SWMH_ST_RST] <= 1'b0;
         if (read_ack && ptr_reg == `SWMH_ADDR_STATE)
            state_reg[`SWMH_ST_LL] <= line_level;
         if (op_done)
         begin
            unique case (op_kind)
               SWMH_OP_TRIPLET:
               begin
                  state_reg[`SWMH_ST_DIR] <= res_dir;
                  state_reg[`SWMH_ST_TSB] <= res_second;
                  state_reg[`SWMH_ST_SBR] <= res_first;
               end
               SWMH_OP_BIT:
                  state_reg[`SWMH_ST_SBR] <= res_first;
               SWMH_OP_RESET:
               begin
                  state_reg[`SWMH_ST_SD]  <= res_short;
                  state_reg[`SWMH_ST_PPD] <= res_presence && !res_short;
               end
               default: ;
            endcase
         end
      end
   end

   // ==================================================
   // received byte, captured when a read-byte completes
   always_ff @(posedge clk_sys)
   begin
      if (reset)
         rxbyte_reg <= 8'h00;
      else if (op_done && op_kind == SWMH_OP_RBYTE)
         rxbyte_reg <= res_byte;
   end

   // ==================================================
   // read multiplexer, registered so data leaves a flip-flop
   always_comb
   begin
      mux_next = `SWMH_RESERVED_READ;
      unique case (region_of(ptr_reg))
         SWMH_RG_SCRATCH: mux_next = scr_rd;
         SWMH_RG_PAGE:    mux_next = pg_rd;
         SWMH_RG_REG:
         begin
            unique case (ptr_reg)
               `SWMH_ADDR_STATE:  mux_next = {state_reg[7:1], line_active};
               `SWMH_ADDR_RXBYTE: mux_next = rxbyte_reg;
               `SWMH_ADDR_SETUP:  mux_next = {4'h0, setup_reg};
               `SWMH_ADDR_RSTL:   mux_next = rstl_reg;
               `SWMH_ADDR_MSP:    mux_next = msp_reg;
               `SWMH_ADDR_WOL:    mux_next = wol_reg;
               `SWMH_ADDR_REC:    mux_next = rec_reg;
               `SWMH_ADDR_WPU:    mux_next = wpu_reg;
               `SWMH_ADDR_W1L:    mux_next = w1l_reg;
               default:           mux_next = `SWMH_RESERVED_READ; // command reads back fixed
            endcase
         end
         default:
         begin
            // identity bytes in the low nonvolatile strip
            if (ptr_reg == `SWMH_ADDR_FACTORY)
               mux_next = `SWMH_FACTORY_VALUE;  // arbitrary value
            else if (ptr_reg == `SWMH_ADDR_PERSON)
               mux_next = `SWMH_PERSON_VALUE;   // arbitrary value
         end
      endcase
   end

   // one cycle late; the storage blocks read synchronously too
   always_ff @(posedge clk_sys)
   begin
      if (reset)
         read_data <= 8'h00;
      else
         read_data <= mux_next;
   end

   assign setup_bits             = setup_reg;
   assign reset_low_time         = rstl_reg;
   assign presence_sample_time   = msp_reg;
   assign write_zero_low_time    = wol_reg;
   assign recovery_time          = rec_reg;
   assign weak_pullup_resistance = wpu_reg;
   assign write_one_low_time     = w1l_reg;

   // ==================================================
   // checks
   sequence setup_good_s;
      data_wr && ptr_reg == `SWMH_ADDR_SETUP && data_in[7:4] == ~data_in[3:0] && !int_reset;
   endsequence

   setup_accept_a: assert property (@(posedge clk_sys) disable iff (reset)
      setup_good_s |=> setup_reg == $past(data_in[3:0]))
      else $error("setup write not accepted");
   setup_reject_a: assert property (@(posedge clk_sys) disable iff (reset)
      data_wr && ptr_reg == `SWMH_ADDR_SETUP && data_in[7:4] != ~data_in[3:0] && !int_reset
      |=> $stable(setup_reg))
      else $error("bad setup write accepted");
   rst_flag_clear_a: assert property (@(posedge clk_sys) disable iff (reset)
      setup_good_s |=> !state_reg[`SWMH_ST_RST])
      else $error("reset flag not cleared");
   rst_flag_set_a: assert property (@(posedge clk_sys)
      int_reset |=> state_reg[`SWMH_ST_RST])
      else $error("reset flag not set");
   ptr_status_a: assert property (@(posedge clk_sys) disable iff (reset)
      wr_cmd && cmd_have_reg && !addr_wr |=> ptr_reg == `SWMH_ADDR_STATE)
      else $error("pointer not at status");
   ptr_incr_a: assert property (@(posedge clk_sys) disable iff (reset)
      read_take && !addr_wr && !data_wr |=> ptr_reg == $past(ptr_reg) + 8'h01)
      else $error("pointer not advanced");
   rx_capture_a: assert property (@(posedge clk_sys) disable iff (reset)
      op_done && op_kind == SWMH_OP_RBYTE |=> rxbyte_reg == $past(res_byte))
      else $error("read byte not stored");
   dir_hold_a: assert property (@(posedge clk_sys) disable iff (reset)
      !(op_done && op_kind == SWMH_OP_TRIPLET) && !int_reset
      |=> $stable(state_reg[`SWMH_ST_DIR]))
      else $error("direction bit moved");
   short_ppd_a: assert property (@(posedge clk_sys) disable iff (reset)
      op_done && op_kind == SWMH_OP_RESET && res_short && !int_reset
      |=> state_reg[`SWMH_ST_SD] && !state_reg[`SWMH_ST_PPD])
      else $error("short reset flags wrong");
   reserved_read_a: assert property (@(posedge clk_sys) disable iff (reset)
      region_of(ptr_reg) == SWMH_RG_NONE && ptr_reg != `SWMH_ADDR_FACTORY
      && ptr_reg != `SWMH_ADDR_PERSON |=> read_data == `SWMH_RESERVED_READ)
      else $error("reserved read not fixed");
endmodule // swmh_regbank
`default_nettype wire

/* File: swmh_params.svh */
// constants for the single-wire master host register bank
`ifndef SWMH_PARAMS_SVH
`define SWMH_PARAMS_SVH

// ==================================================
// address map
`define SWMH_SCRATCH_FIRST   8'h00
`define SWMH_SCRATCH_LAST    8'h4b
`define SWMH_SCRATCH_DEPTH   76
`define SWMH_REG_BASE        8'h60
`define SWMH_NV_BASE         8'h70
`define SWMH_ADDR_CMD        8'h60
`define SWMH_ADDR_STATE      8'h61
`define SWMH_ADDR_RXBYTE     8'h62
`define SWMH_ADDR_SETUP      8'h67
`define SWMH_ADDR_RSTL       8'h68
`define SWMH_ADDR_MSP        8'h69
`define SWMH_ADDR_WOL        8'h6a
`define SWMH_ADDR_REC        8'h6b
`define SWMH_ADDR_WPU        8'h6c
`define SWMH_ADDR_W1L        8'h6d
`define SWMH_ADDR_FACTORY    8'h70
`define SWMH_ADDR_PERSON     8'h73
`define SWMH_PAGE0_FIRST     8'h80
`define SWMH_PAGE1_LAST      8'hbf
`define SWMH_PAGE_DEPTH      64

// ==================================================
// status bit positions
`define SWMH_ST_DIR          7
`define SWMH_ST_TSB          6
`define SWMH_ST_SBR          5
`define SWMH_ST_RST          4
`define SWMH_ST_LL           3
`define SWMH_ST_SD           2
`define SWMH_ST_PPD          1
`define SWMH_ST_BUSY         0

// ==================================================
// reset values and fillers
`define SWMH_SETUP_RESET     8'h00
`define SWMH_RSTL_RESET      8'h06
`define SWMH_MSP_RESET       8'h06
`define SWMH_WOL_RESET       8'h06
`define SWMH_REC_RESET       8'h06
`define SWMH_WPU_RESET       8'h06
`define SWMH_W1L_RESET       8'h06
`define SWMH_RESERVED_READ   8'hff
`define SWMH_FACTORY_VALUE   8'h5a
`define SWMH_PERSON_VALUE    8'ha5

`endif

/* File: swmh_pkg.sv */
// types for the single-wire master host register bank
package swmh_pkg;
   // kind of line operation reported by the line engine
   typedef enum logic [2:0]
   {
      SWMH_OP_NONE    = 3'b000,
      SWMH_OP_RESET   = 3'b001,
      SWMH_OP_BIT     = 3'b010,
      SWMH_OP_WBYTE   = 3'b011,
      SWMH_OP_RBYTE   = 3'b100,
      SWMH_OP_TRIPLET = 3'b101,
      SWMH_OP_MRESET  = 3'b110
   } swmh_op_t;

   // region that an address falls into
   typedef enum logic [1:0]
   {
      SWMH_RG_SCRATCH = 2'b00,
      SWMH_RG_REG     = 2'b01,
      SWMH_RG_PAGE    = 2'b10,
      SWMH_RG_NONE    = 2'b11
   } swmh_region_t;
endpackage

/* File: swmh_scratch.sv */
// input scratchpad storage, byte wide
`timescale 1ns/10ps
`default_nettype none
`include "swmh_params.svh"
module swmh_scratch
   import swmh_pkg::*;
(
   // clock
   input  wire logic       clk_sys,
   // write port
   input  wire logic       wr_en,
   input  wire logic [6:0] wr_idx,
   input  wire logic [7:0] wr_data,
   // read port
   input  wire logic [6:0] rd_idx,
   output var  logic [7:0] rd_data
);
   // volatile contents, undefined after power-on by nature
   logic [7:0] mem [0:`SWMH_SCRATCH_DEPTH-1];

   // ==================================================
   // write and registered read
   always_ff @(posedge clk_sys)
   begin
      if (wr_en)
      begin
         mem[wr_idx] <= wr_data;
      end
      rd_data <= mem[rd_idx];
   end
endmodule // swmh_scratch
`default_nettype wire

/* File: swmh_pages.sv */
// user memory pages, two pages of 32 bytes
`timescale 1ns/10ps
`default_nettype none
`include "swmh_params.svh"
module swmh_pages
   import swmh_pkg::*;
(
   // clock
   input  wire logic       clk_sys,
   // write port
   input  wire logic       wr_en,
   input  wire logic [5:0] wr_idx,
   input  wire logic [7:0] wr_data,
   // read port
   input  wire logic [5:0] rd_idx,
   output var  logic [7:0] rd_data
);
   // nonvolatile in silicon; modelled as plain storage here
   logic [7:0] mem [0:`SWMH_PAGE_DEPTH-1];

   // ==================================================
   // write and registered read
   always_ff @(posedge clk_sys)
   begin
      if (wr_en)
      begin
         mem[wr_idx] <= wr_data;
      end
      rd_data <= mem[rd_idx];
   end
endmodule // swmh_pages
`default_nettype wire

/* File: swmh_line_model.sv */
// line engine stand-in that answers commands from the register bank
`timescale 1ns/10ps
`default_nettype none
module swmh_line_model
   import swmh_pkg::*;
(
   // clock and reset
   input  wire logic       clk_sys,
   input  wire logic       reset,
   // command from the bank
   input  wire logic       cmd_valid,
   input  wire logic [7:0] cmd_param,
   input  wire swmh_op_t   op_sel,
   // results back to the bank
   output var  logic       line_active,
   output var  logic       op_done,
   output var  swmh_op_t   op_kind,
   output var  logic [4:0] res_bits,
   output var  logic [7:0] res_byte
);
   // ==================================================
   // busy span
   logic [4:0] cnt_reg;   // cycles left on the line
   logic [7:0] junk_reg;  // changing filler outside op_done

   // busy for a fixed span per command, done pulse when it ends
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         cnt_reg     <= 5'h00;
         line_active <= 1'b0;
         op_done     <= 1'b0;
         junk_reg    <= 8'h00;
      end
      else
      begin
         junk_reg <= junk_reg + 8'h5b;
         op_done  <= (cnt_reg == 5'h01);
         // busy stays up for the whole line exchange
         if (cmd_valid)
         begin
            cnt_reg     <= 5'h14;
            line_active <= 1'b1;
         end
         else if (cnt_reg != 5'h00)
         begin
            cnt_reg     <= cnt_reg - 5'h01;
            line_active <= (cnt_reg != 5'h01);
         end
      end
   end

   // ==================================================
   // results
   // results from the parameter; filler otherwise so stale values never look valid
   assign op_kind  = op_done ? op_sel : SWMH_OP_NONE;
   assign res_bits = op_done ? cmd_param[4:0] : junk_reg[4:0];
   assign res_byte = op_done ? ~cmd_param : junk_reg;
endmodule // swmh_line_model
`default_nettype wire

/* File: single_wire_master_host_registers_tb_top.sv */
// self-checking bench for the single-wire master host register bank
`timescale 1ns/10ps
`default_nettype none
module single_wire_master_host_registers_tb_top
   import swmh_pkg::*;
;
   // ==================================================
   // stimulus and wiring
   logic       clk_sys = 1'b0;   // system clock
   logic       reset = 1'b1;     // sync reset
   logic       sleep_pin_n = 1'b1;
   logic       addr_wr = 1'b0, data_wr = 1'b0, read_ack = 1'b0, read_take = 1'b0;
   logic [7:0] addr_in = 8'h00, data_in = 8'h00, read_data, cmd_code, cmd_param, res_byte;
   logic       line_level = 1'b0, line_active, op_done, cmd_valid;
   logic [4:0] res_bits;         // first, second, dir, short, presence
   swmh_op_t   op_kind, op_sel = SWMH_OP_NONE;
   wire [3:0]       setup_bits;    // setup nibble seen by the line side
   wire [5:0][7:0]  tim;           // timing outputs, 68h to 6dh in order
   int         n_errors = 0, n_tests = 0, n_cmd = 0;

   always #2 clk_sys = ~clk_sys;
   // count command hand-offs seen by the engine
   always @(posedge clk_sys) if (cmd_valid === 1'b1) n_cmd <= n_cmd + 1;

   swmh_regbank DUT (.clk_sys(clk_sys), .reset(reset), .sleep_pin_n(sleep_pin_n),
      .addr_wr(addr_wr), .addr_in(addr_in), .data_wr(data_wr), .data_in(data_in),
      .read_ack(read_ack), .read_take(read_take), .read_data(read_data),
      .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_param(cmd_param),
      .line_level(line_level), .line_active(line_active), .op_done(op_done),
      .op_kind(op_kind), .res_first(res_bits[0]), .res_second(res_bits[1]),
      .res_dir(res_bits[2]), .res_short(res_bits[3]), .res_presence(res_bits[4]),
      .res_byte(res_byte), .setup_bits(setup_bits), .reset_low_time(tim[0]),
      .presence_sample_time(tim[1]), .write_zero_low_time(tim[2]),
      .recovery_time(tim[3]), .weak_pullup_resistance(tim[4]),
      .write_one_low_time(tim[5]));
   swmh_line_model u_line (.clk_sys(clk_sys), .reset(reset), .cmd_valid(cmd_valid),
      .cmd_param(cmd_param), .op_sel(op_sel), .line_active(line_active),
      .op_done(op_done), .op_kind(op_kind), .res_bits(res_bits), .res_byte(res_byte));

   // ==================================================
   // host byte tasks
   task set_ptr(input logic [7:0] a);
      @(posedge clk_sys); addr_wr <= 1'b1; addr_in <= a;
      @(posedge clk_sys); addr_wr <= 1'b0;
   endtask
   task wr(input logic [7:0] d);
      @(posedge clk_sys); data_wr <= 1'b1; data_in <= d;
      @(posedge clk_sys); data_wr <= 1'b0;
   endtask
   // read_data settles two edges after the pointer moves; one spare edge
   task rd(output logic [7:0] d);
      repeat (3) @(posedge clk_sys);
      #1 d = read_data;
      @(posedge clk_sys); read_take <= 1'b1;
      @(posedge clk_sys); read_take <= 1'b0;
   endtask
   task pulse_ack();
      @(posedge clk_sys); read_ack <= 1'b1;
      @(posedge clk_sys); read_ack <= 1'b0;
   endtask
   task chk(input logic [7:0] seen, input logic [7:0] exp, input string msg);
      n_tests++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("[FAIL] %0t %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask
   task chk_at(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] v;
      set_ptr(a);
      rd(v);
      chk(v, exp, $sformatf("read of %h", a));
   endtask
   // code then parameter, both into the command entry
   task cmd(input logic [7:0] c, input logic [7:0] p);
      set_ptr(8'h60);
      wr(c);
      wr(p);
   endtask
   // bounded wait for the line to go quiet, then let status land
   task wait_idle();
      for (int k = 0; k < 100 && line_active !== 1'b0; k++) @(posedge clk_sys);
      repeat (4) @(posedge clk_sys);
      #1;
      // a wait that ran out leaves busy up and counts as a mismatch
      chk({7'h0, line_active}, 8'h00, "busy at end");
   endtask

   // ==================================================
   // scenarios
   task t_reset();
      chk_at(8'h61, 8'h10);
      chk_at(8'h67, 8'h00);
      for (int a = 8'h68; a <= 8'h6d; a++) chk_at(8'(a), 8'h06);
      for (int j = 0; j < 6; j++) chk(tim[j], 8'h06, "timing output");
      chk_at(8'h70, 8'h5a);
      chk_at(8'h73, 8'ha5);
      $display("test reset done");
   endtask
   task t_memory();
      logic [7:0] v;
      set_ptr(8'h00); wr(8'h11); wr(8'h22);
      set_ptr(8'h4b); wr(8'h33);
      set_ptr(8'h80); wr(8'h44);
      set_ptr(8'ha0); wr(8'h55);
      set_ptr(8'h00); rd(v);
      chk(v, 8'h11, "scratch first");
      rd(v);
      chk(v, 8'h22, "pointer step");
      chk_at(8'h4b, 8'h33);
      chk_at(8'h80, 8'h44);
      chk_at(8'ha0, 8'h55);
      $display("test memory done");
   endtask
   task automatic t_reserved();
      logic [7:0] ra[7] = '{8'h4c, 8'h5f, 8'h66, 8'h6e, 8'h74, 8'hc0, 8'hff};
      foreach (ra[i])
      begin
         set_ptr(ra[i]); wr(8'h00);
         chk_at(ra[i], 8'hff);
      end
      chk_at(8'h60, 8'hff);
      set_ptr(8'h70); wr(8'h00);
      chk_at(8'h70, 8'h5a);
      $display("test reserved done");
   endtask
   task t_setup();
      set_ptr(8'h68); wr(8'h5a);
      chk_at(8'h68, 8'h5a);
      chk(tim[0], 8'h5a, "timing output written");
      set_ptr(8'h67); wr(8'h11);
      chk_at(8'h67, 8'h00);
      chk_at(8'h61, 8'h10);
      set_ptr(8'h67); wr(8'he1);
      chk_at(8'h67, 8'h01);
      chk({4'h0, setup_bits}, 8'h01, "setup output");
      chk_at(8'h61, 8'h00);
      @(posedge clk_sys); sleep_pin_n <= 1'b0;
      repeat (3) @(posedge clk_sys); sleep_pin_n <= 1'b1;
      chk_at(8'h61, 8'h10);
      chk_at(8'h67, 8'h00);
      chk({4'h0, setup_bits}, 8'h00, "setup output reset");
      set_ptr(8'h67); wr(8'he1);
      $display("test setup done");
   endtask
   task t_level();
      set_ptr(8'h61); line_level <= 1'b1; pulse_ack();
      chk_at(8'h61, 8'h08);
      set_ptr(8'h62); line_level <= 1'b0; pulse_ack();
      chk_at(8'h61, 8'h08);
      set_ptr(8'h61); pulse_ack();
      chk_at(8'h61, 8'h00);
      $display("test level done");
   endtask
   task automatic t_commands();
      swmh_op_t   op[6] = '{SWMH_OP_RESET, SWMH_OP_TRIPLET, SWMH_OP_BIT,
                            SWMH_OP_RESET, SWMH_OP_WBYTE, SWMH_OP_RBYTE};
      logic [7:0] pr[6] = '{8'h18, 8'h07, 8'h00, 8'h10, 8'h07, 8'h3c};
      logic [7:0] ex[6] = '{8'h04, 8'he4, 8'hc4, 8'hc2, 8'hc2, 8'hc2};
      int         c0;
      foreach (op[i])
      begin
         @(posedge clk_sys);
         op_sel <= op[i];
         c0 = n_cmd;
         cmd(8'h20 + 8'(i), pr[i]);
         repeat (3) @(posedge clk_sys);
         #1 chk(read_data & 8'h01, 8'h01, "busy");
         chk(cmd_code, 8'h20 + 8'(i), "code");
         chk(cmd_param, pr[i], "parameter");
         chk(8'(n_cmd - c0), 8'h01, "one hand-off");
         wait_idle();
         chk(read_data, ex[i], "status");
      end
      // busy clear, then point at the data byte and read it
      chk_at(8'h62, 8'hc3);
      set_ptr(8'h62); wr(8'h00);
      chk_at(8'h62, 8'hc3);
      op_sel <= SWMH_OP_NONE;
      // a lone code is dropped when the host re-addresses the entry
      c0 = n_cmd;
      set_ptr(8'h60);
      wr(8'h2a);
      cmd(8'h2b, 8'h01);
      repeat (3) @(posedge clk_sys);
      #1 chk(cmd_code, 8'h2b, "lone code dropped");
      chk(8'(n_cmd - c0), 8'h01, "one pair only");
      wait_idle();
      set_ptr(8'h60); wr(8'hf0);
      wait_idle();
      chk(read_data, 8'h10, "master reset");
      $display("test commands done");
   endtask

   // ==================================================
   // sequence, watchdog and verdict
   task end_sim();
      $display("checks %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial
   begin
      repeat (6) @(posedge clk_sys);
      reset <= 1'b0;
      t_reset();
      t_memory();
      t_reserved();
      t_setup();
      t_level();
      t_commands();
      end_sim();
   end
   // the run needs well under a thousand cycles; this cuts a hang short
   initial
   begin
      repeat (30000) @(posedge clk_sys);
      n_errors++;
      end_sim();
   end
endmodule // single_wire_master_host_registers_tb_top
`default_nettype wire
